// ---- periph_irq_mask.sv ----
/*
 * Peripheral interrupt enable mask with request flags and a combined
 * interrupt request, reached over APB.
 * Assumes event inputs come from peripheral logic on pclk and the
 * global enable sits outside this block.
 */
`timescale 1ns/1ps

module periph_irq_mask
	import periph_irq_pkg::*;
(
	input  wire logic              pclk,               // APB clock
	input  wire logic              presetn,            // APB reset, low
	input  wire logic              psel,               // Slave select
	input  wire logic              penable,            // Access phase
	input  wire logic              pwrite,             // Write when high
	input  wire logic [ADDR_W-1:0] paddr,              // Byte address
	input  wire logic [DATA_W-1:0] pwdata,             // Write data
	input  wire logic [3:0]        pstrb,              // Byte strobes
	output logic      [DATA_W-1:0] prdata,             // Read data
	output logic                   pready,             // Transfer ready
	output logic                   pslverr,            // Unmapped access
	input  wire logic              conv_done_evt,      // Conversion done
	input  wire logic              serial_port_evt,    // Serial transfer done
	input  wire logic              capcmp_evt,         // Capture/compare event
	input  wire logic              period_match_evt,   // Period timer match
	input  wire logic              timer_overflow_evt, // Overflow timer wrap
	output logic      [IRQ_W-1:0]  irq_pending,        // Flag AND mask
	output logic                   periph_irq          // Combined request
);

	// ********************************************************
	// Address decode
	// ********************************************************
	logic [ADDR_W-1:0] word_addr;
	logic              sel_mask;
	logic              sel_flag;
	logic              sel_pend;
	logic              mapped;
	logic              setup_phase;
	logic              access_done;
	logic              pready_reg;

	assign word_addr   = {paddr[ADDR_W-1:2], 2'b00};
	assign sel_mask    = (word_addr == MASK_OFFSET);
	assign sel_flag    = (word_addr == FLAG_OFFSET);
	assign sel_pend    = (word_addr == PEND_OFFSET);
	assign mapped      = sel_mask | sel_flag | sel_pend;
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready_reg;

	// ********************************************************
	// Write strobes
	// ********************************************************
	logic              wr_low_byte;
	logic              wr_mask;
	logic              wr_flag;
	logic [7:0]        wr_byte;

	assign wr_low_byte = access_done & pwrite & pstrb[0];
	assign wr_mask     = wr_low_byte & sel_mask;
	assign wr_flag     = wr_low_byte & sel_flag;
	assign wr_byte     = pwdata[7:0];

	// ********************************************************
	// Mask register
	// ********************************************************
	logic [7:0]        mask_reg;
	logic [7:0]        mask_next;

	assign mask_next = wr_mask ? impl_bits(wr_byte) : mask_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= MASK_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// ********************************************************
	// Request flags
	// ********************************************************
	logic [7:0]        event_vec;
	logic [7:0]        flag_clr;
	logic [7:0]        flags;
	logic [7:0]        flags_nxt;

	// Events land in their flags whatever the mask holds
	always_comb begin
		event_vec                = 8'h00;
		event_vec[CONV_DONE_BIT] = conv_done_evt;
		event_vec[SERIAL_BIT]    = serial_port_evt;
		event_vec[CAPCMP_BIT]    = capcmp_evt;
		event_vec[PERIOD_BIT]    = period_match_evt;
		event_vec[TIMER_OVF_BIT] = timer_overflow_evt;
	end

	// Write one to clear
	assign flag_clr = wr_flag ? impl_bits(wr_byte) : 8'h00;

	sticky_flags #(
		.WIDTH     (IRQ_W),
		.RESET_VAL (FLAG_RESET)
	) u_flags (
		.clk       (pclk),
		.rst_n     (presetn),
		.set_vec   (event_vec),
		.clr_vec   (flag_clr),
		.flags     (flags),
		.flags_nxt (flags_nxt)
	);

	// ********************************************************
	// Gating and combined request
	// ********************************************************
	logic [7:0]        gated_next;
	logic              conv_req;
	logic              serial_req;
	logic              capcmp_req;
	logic              period_req;
	logic              ovf_req;
	logic              any_req_next;

	assign conv_req   = flags_nxt[CONV_DONE_BIT] & mask_next[CONV_DONE_BIT];
	assign serial_req = flags_nxt[SERIAL_BIT]    & mask_next[SERIAL_BIT];
	assign capcmp_req = flags_nxt[CAPCMP_BIT]    & mask_next[CAPCMP_BIT];
	assign period_req = flags_nxt[PERIOD_BIT]    & mask_next[PERIOD_BIT];
	assign ovf_req    = flags_nxt[TIMER_OVF_BIT] & mask_next[TIMER_OVF_BIT];

	always_comb begin
		gated_next                = 8'h00;
		gated_next[CONV_DONE_BIT] = conv_req;
		gated_next[SERIAL_BIT]    = serial_req;
		gated_next[CAPCMP_BIT]    = capcmp_req;
		gated_next[PERIOD_BIT]    = period_req;
		gated_next[TIMER_OVF_BIT] = ovf_req;
	end

	assign any_req_next = |gated_next;

	logic [7:0]        pending_reg;
	logic              irq_reg;

	// Registered so outputs track the held flags and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= 8'h00;
			irq_reg     <= 1'b0;
		end else begin
			pending_reg <= gated_next;
			irq_reg     <= any_req_next;
		end
	end

	assign irq_pending = pending_reg;
	assign periph_irq  = irq_reg;

	// ********************************************************
	// Read mux, sampled in the setup cycle
	// ********************************************************
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] pend_word;

	assign pend_word = low_byte_word(pending_reg) | ({31'h00000000, irq_reg} << PEND_ANY_BIT);

	always_comb begin
		rd_word = 32'h00000000;
		if (sel_mask) begin
			rd_word = low_byte_word(impl_bits(mask_reg));
		end else if (sel_flag) begin
			rd_word = low_byte_word(impl_bits(flags));
		end else if (sel_pend) begin
			rd_word = pend_word;
		end
	end

	// ********************************************************
	// APB response: one wait-free access after setup
	// ********************************************************
	logic [DATA_W-1:0] prdata_reg;
	logic              pslverr_reg;
	logic [DATA_W-1:0] prdata_next;
	logic              pready_next;
	logic              pslverr_next;

	assign pready_next  = setup_phase;
	assign pslverr_next = setup_phase & ~mapped;
	assign prdata_next  = (setup_phase & ~pwrite & mapped) ? rd_word :
	                      (access_done ? 32'h00000000 : prdata_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h00000000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

endmodule : periph_irq_mask

// ---- periph_irq_mask_monitor.sv ----
/* Port checker for periph_irq_mask.
 * Assumes a bind onto the top module and one pclk domain. */
`timescale 1ns/1ps

module periph_irq_mask_monitor
	import periph_irq_pkg::*;
(
	input wire logic              pclk,               // Clock
	input wire logic              presetn,            // Reset, low
	input wire logic              psel,               // Select
	input wire logic              penable,            // Access
	input wire logic              pwrite,             // Write
	input wire logic [ADDR_W-1:0] paddr,              // Address
	input wire logic [DATA_W-1:0] pwdata,             // Write data
	input wire logic [3:0]        pstrb,              // Strobes
	input wire logic [DATA_W-1:0] prdata,             // Read data
	input wire logic              pready,             // Ready
	input wire logic              pslverr,            // Error
	input wire logic              conv_done_evt,      // Event
	input wire logic              serial_port_evt,    // Event
	input wire logic              capcmp_evt,         // Event
	input wire logic              period_match_evt,   // Event
	input wire logic              timer_overflow_evt, // Event
	input wire logic [IRQ_W-1:0]  irq_pending,        // Pending
	input wire logic              periph_irq          // Request
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wire logic       acc_done = psel && penable && pready;
	wire logic       wr_mask  = acc_done && pwrite && pstrb[0] && paddr[11:2] == MASK_OFFSET[11:2];
	wire logic       wr_flag  = acc_done && pwrite && pstrb[0] && paddr[11:2] == FLAG_OFFSET[11:2];
	wire logic [7:0] evt_vec  = {1'b0, conv_done_evt, 2'b00, serial_port_evt, capcmp_evt, period_match_evt,
		timer_overflow_evt};

	property p_pend_unimpl;
		irq_pending[7] == 1'b0 && irq_pending[5:4] == 2'b00;
	endproperty
	a_pend_unimpl: assert property (p_pend_unimpl) else $error("pending unimplemented bit set");
	property p_rd_unimpl;
		acc_done && !pwrite && !pslverr |-> prdata[7] == 1'b0 && prdata[5:4] == 2'b00;
	endproperty
	a_rd_unimpl: assert property (p_rd_unimpl) else $error("read unimplemented bit set");
	property p_irq_or;
		periph_irq == |irq_pending;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("request not OR of pending");
	property p_rise;
		|(irq_pending & ~$past(irq_pending) & ~$past(evt_vec)) |-> $past(wr_mask);
	endproperty
	a_rise: assert property (p_rise) else $error("pending rose without cause");
	property p_fall;
		|($past(irq_pending) & ~irq_pending) |-> $past(wr_mask || wr_flag);
	endproperty
	a_fall: assert property (p_fall) else $error("pending fell without write");
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_err;
		pslverr |-> pready && paddr[11:2] > 10'd2;
	endproperty
	a_err: assert property (p_err) else $error("error on mapped address");
	property p_rd_idle;
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside transfer");
endmodule : periph_irq_mask_monitor

// ---- periph_irq_mask_tb.sv ----
/* Testbench for periph_irq_mask: APB driver, note queue, checker.
 * Assumes the package and the monitor are compiled first. */
`timescale 1ns/1ps

module periph_irq_mask_tb
	import periph_irq_pkg::*;
;
	logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic [3:0]        pstrb = '0;
	logic [7:0]        evt_bus = '0, mask_m = '0, flag_m = '0;
	logic [7:0]        src[5] = '{8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
	logic [IRQ_W-1:0]  irq_pending;
	logic              pready, pslverr, periph_irq;
	logic [42:0]       notes[$];
	logic [42:0]       nt;
	int                fail_count = 0, cmp_count = 0;
	integer            seed = 32'h1bd4a345;

	initial forever #4 pclk = ~pclk;

	periph_irq_mask u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .conv_done_evt(evt_bus[6]), .serial_port_evt(evt_bus[3]),
		.capcmp_evt(evt_bus[2]), .period_match_evt(evt_bus[1]), .timer_overflow_evt(evt_bus[0]),
		.irq_pending, .periph_irq);

	task automatic tally_and_finish;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	// Note layout: pending, read, error, request, data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [42:0] note);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		notes.push_back(note);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			tally_and_finish;
		end
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic rd(input logic [11:0] a);
		logic [7:0]  p;
		logic [31:0] d;
		p = flag_m & mask_m;
		d = a == MASK_OFFSET ? {24'h0, mask_m} : a == FLAG_OFFSET ? {24'h0, flag_m} :
			a == PEND_OFFSET ? {23'h0, |p, p} : 32'h0;
		apb(1'b0, a, $random(seed), 4'hf, {p, 1'b1, a[11:2] > 10'd2, |p, d});
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s, {8'h00, 1'b0, a[11:2] > 10'd2, 33'h0});
		if (s[0] && a == MASK_OFFSET) mask_m = d[7:0] & IMPL_MASK;
		if (s[0] && a == FLAG_OFFSET) flag_m = flag_m & ~d[7:0];
	endtask : wr

	task automatic pulse(input logic [7:0] v);
		@(posedge pclk);
		evt_bus <= v;
		@(posedge pclk);
		evt_bus <= 8'h00;
		flag_m = flag_m | (v & IMPL_MASK);
	endtask : pulse

	// Checker: oldest note against each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			nt = notes.size() ? notes.pop_front() : '1;
			if (nt[34]) chk("prdata", nt[31:0], prdata);
			if (nt[34]) chk("periph_irq", {31'h0, nt[32]}, {31'h0, periph_irq});
			if (nt[34]) chk("irq_pending", {24'h0, nt[42:35]}, {24'h0, irq_pending});
			chk("pslverr", {31'h0, nt[33]}, {31'h0, pslverr});
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(MASK_OFFSET);
		rd(PEND_OFFSET);
		rd(12'h00c);
		wr(12'h010, 32'hffffffff, 4'hf);
		wr(MASK_OFFSET, 32'hffffffff, 4'he);
		rd(MASK_OFFSET);
		wr(MASK_OFFSET, 32'hffffffff, 4'h1);
		rd(MASK_OFFSET);
		wr(PEND_OFFSET, 32'hffffffff, 4'hf);
		rd(PEND_OFFSET);
		wr(MASK_OFFSET, 32'h0, 4'hf);
		foreach (src[i]) begin
			pulse(src[i]);
			rd(FLAG_OFFSET);
			rd(PEND_OFFSET);
			wr(FLAG_OFFSET, {24'h0, src[i]}, 4'h1);
			wr(MASK_OFFSET, {24'h0, src[i]}, 4'h1);
			pulse(src[i]);
			rd(PEND_OFFSET);
			wr(MASK_OFFSET, 32'h0, 4'h1);
			rd(PEND_OFFSET);
			wr(FLAG_OFFSET, {24'h0, src[i]}, 4'h1);
		end
		// Events held across a clear: the set must win
		evt_bus <= IMPL_MASK;
		wr(FLAG_OFFSET, 32'h000000ff, 4'h1);
		evt_bus <= 8'h00;
		flag_m = IMPL_MASK;
		rd(FLAG_OFFSET);
		repeat (12) begin
			pulse(8'($random(seed)));
			wr(MASK_OFFSET, $random(seed), 4'hf);
			rd(PEND_OFFSET);
			wr(FLAG_OFFSET, $random(seed), 4'hf);
			rd(FLAG_OFFSET);
		end
		tally_and_finish;
	end
endmodule : periph_irq_mask_tb

bind periph_irq_mask periph_irq_mask_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .conv_done_evt, .serial_port_evt, .capcmp_evt,
	.period_match_evt, .timer_overflow_evt, .irq_pending, .periph_irq);

// ---- periph_irq_pkg.sv ----
/*
 * Constants for the peripheral interrupt enable mask block: register
 * offsets, bit positions, reset values and small helper functions.
 * Assumes a 32-bit APB register bus with byte addresses and one clock.
 */
//
// Functional notes
// - Unimplemented mask bits read zero, ignore writes
// - Converter enable gates conversion-complete flag request
// - Serial port enable gates transfer-done request
// - Capture/compare enable gates its event request
// - Period-match enable gates period timer request
// - Overflow enable gates overflow timer request
// - Flags set on events regardless of mask
package periph_irq_pkg;

	// ********************************************************
	// Bus and register geometry
	// ********************************************************
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam int          IRQ_W           = 8;

	localparam logic [11:0] MASK_OFFSET     = 12'h000;
	localparam logic [11:0] FLAG_OFFSET     = 12'h004;
	localparam logic [11:0] PEND_OFFSET     = 12'h008;

	// ********************************************************
	// Field positions, all but PEND_ANY_BIT shared by mask, flag and pending words
	// ********************************************************
	localparam int          TIMER_OVF_BIT   = 0;
	localparam int          PERIOD_BIT      = 1;
	localparam int          CAPCMP_BIT      = 2;
	localparam int          SERIAL_BIT      = 3;
	localparam int          CONV_DONE_BIT   = 6;
	localparam int          PEND_ANY_BIT    = 8;

	// Implemented positions: bits 6, 3, 2, 1 and 0
	localparam logic [7:0]  IMPL_MASK       = 8'h4f;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [7:0]  MASK_RESET      = 8'h00;
	localparam logic [7:0]  FLAG_RESET      = 8'h00;

	// Keep only implemented positions
	function automatic logic [7:0] impl_bits(input logic [7:0] value);
		impl_bits = value & IMPL_MASK;
	endfunction : impl_bits

	// Place a byte in the low lane of a read word
	function automatic logic [31:0] low_byte_word(input logic [7:0] value);
		low_byte_word = {24'h000000, value};
	endfunction : low_byte_word

endpackage : periph_irq_pkg

// ---- sticky_flags.sv ----
/*
 * Bank of sticky event flags: set by hardware, cleared by software.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps

module sticky_flags
	import periph_irq_pkg::*;
#(
	parameter int         WIDTH     = IRQ_W,
	parameter logic [7:0] RESET_VAL = FLAG_RESET
) (
	input  wire logic             clk,       // Core clock
	input  wire logic             rst_n,     // Async reset, low
	input  wire logic [WIDTH-1:0] set_vec,   // Event per bit
	input  wire logic [WIDTH-1:0] clr_vec,   // Clear per bit
	output logic      [WIDTH-1:0] flags,     // Held flags
	output logic      [WIDTH-1:0] flags_nxt  // Next flag value
);

	// ********************************************************
	// Next value: a set in the clear cycle wins
	// ********************************************************
	logic [WIDTH-1:0] flags_reg;
	logic [WIDTH-1:0] flags_next;

	assign flags_next = set_vec | (flags_reg & ~clr_vec);
	assign flags      = flags_reg;
	assign flags_nxt  = flags_next;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= RESET_VAL[WIDTH-1:0];
		end else begin
			flags_reg <= flags_next;
		end
	end

endmodule : sticky_flags
